// ---- include/radio_regs_pkg.sv ----
package radio_regs_pkg;

  // ==========================================================================
  // register map
  localparam logic [5:0] ADDR_STRENGTH   = 6'h22;
  localparam logic [5:0] ADDR_GAIN       = 6'h23;
  localparam logic [5:0] ADDR_TRIM       = 6'h24;
  localparam logic [5:0] ADDR_SLOPE      = 6'h26;
  localparam logic [5:0] ADDR_CONTROL    = 6'h03;
  localparam logic [5:0] ADDR_ANALOG     = 6'h20;

  // ==========================================================================
  // field positions and reset values
  localparam int         RX_ENABLE_BIT   = 7;
  localparam int         DEV_RESET_BIT   = 0;
  localparam int         VALID_BIT       = 5;
  localparam int         CLK_DISABLE_BIT = 6;
  localparam logic [7:0] RESET_VALUE     = 8'h00;
  localparam logic [7:0] UNDEF_READ      = 8'h00;

  // ==========================================================================
  // slope select encodings
  localparam logic [1:0] SLOPE_WIDE      = 2'h3;
  localparam logic [1:0] SLOPE_NARROW    = 2'h2;
  localparam logic [1:0] SLOPE_RSVD      = 2'h1;
  localparam logic [1:0] SLOPE_NONE      = 2'h0;

  typedef enum logic [1:0] {
    ADJ_NONE,
    ADJ_NARROW,
    ADJ_WIDE
  } slope_adjust_t;

  // register access request from the serial interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// ---- core/radio_tuning_status_regs.sv ----
`timescale 1ns/1ns
`default_nettype none

module radio_tuning_status_regs
  import radio_regs_pkg::*;
(
  input  wire logic                     mclk_in,
  input  wire logic                     nrst_in,
  input  wire radio_regs_pkg::reg_req_t req_in,
  input  wire logic                     rx_sample_in,
  input  wire logic [4:0]               received_strength_value_in,
  input  wire logic                     ref_clock_in,
  output logic [7:0]                    rdata_out,
  output logic                          reference_clock_out_pin_out,
  output logic [2:0]                    amp_gain_setting_out,
  output logic [5:0]                    crystal_trim_out,
  output logic [1:0]                    oscillator_slope_select_out
);
  import radio_regs_pkg::*;

  // ==========================================================================
  // elaboration checks: the byte slices below assume this field layout
  if (VALID_BIT != 5) begin : g_bad_valid_bit
    $error("valid flag must sit just above the five-bit strength value");
  end
  if (CLK_DISABLE_BIT != 6) begin : g_bad_clk_bit
    $error("clock disable must sit just above the six-bit trim code");
  end
  if (RX_ENABLE_BIT > 7 || DEV_RESET_BIT > 7) begin : g_bad_ctrl_bits
    $error("control bit positions must fall inside one byte");
  end
  if (SLOPE_WIDE == SLOPE_NARROW || SLOPE_NARROW == SLOPE_NONE) begin : g_bad_slope_codes
    $error("slope encodings must be distinct");
  end

  // ==========================================================================
  // reset release
  // the block leaves reset two edges after the pin, all flops on one edge
  logic       rst_meta_reg;
  logic       rst_sync_reg;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  wire rst_n = rst_sync_reg;

  // ==========================================================================
  // reference clock sampling: three stages, change counts when last two agree
  // limitation: a level must last two clock periods to pass, so the pin only
  // follows references slower than a quarter of mclk; faster ones read as idle
  logic [2:0] refclk_sync_reg;
  logic       refclk_level_reg;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      refclk_sync_reg  <= 3'h0;
      refclk_level_reg <= 1'b0;
    end else begin
      refclk_sync_reg <= {refclk_sync_reg[1:0], ref_clock_in};
      if (refclk_sync_reg[1] == refclk_sync_reg[2]) begin
        refclk_level_reg <= refclk_sync_reg[2];
      end
    end
  end

  // ==========================================================================
  // decode
  // writes and the device reset all come from the one request word
  wire wr_gain     = req_in.wr && (req_in.addr == ADDR_GAIN);
  wire wr_trim     = req_in.wr && (req_in.addr == ADDR_TRIM);
  wire wr_slope    = req_in.wr && (req_in.addr == ADDR_SLOPE);
  wire wr_control  = req_in.wr && (req_in.addr == ADDR_CONTROL);
  // device reset lasts only the cycle of the write; the analog byte is not stored
  wire dev_reset   = req_in.wr && (req_in.addr == ADDR_ANALOG)
                     && req_in.wdata[DEV_RESET_BIT];

  // ==========================================================================
  // registers
  logic       rx_mode_reg;
  logic       sample_pending_reg;
  logic       valid_reg;
  logic [4:0] strength_reg;
  logic [2:0] gain_reg;
  logic [7:0] trim_reg;
  logic [1:0] slope_reg;
  logic [7:0] rdata_reg;
  logic       refout_reg;

  // entering receive mode arms one capture
  // a second write of bit 7 while still receiving does not re-arm; leaving and
  // entering again does, and clears the valid flag until the new sample lands
  wire rx_enter = wr_control && req_in.wdata[RX_ENABLE_BIT] && !rx_mode_reg;
  // the first strobe after arming is taken, later strobes wait for a new entry
  wire capture  = sample_pending_reg && rx_sample_in;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rx_mode_reg        <= 1'b0;
      sample_pending_reg <= 1'b0;
      valid_reg          <= 1'b0;
      strength_reg       <= 5'h00;
    end else if (dev_reset) begin
      rx_mode_reg        <= 1'b0;
      sample_pending_reg <= 1'b0;
      valid_reg          <= 1'b0;
      strength_reg       <= 5'h00;
    end else begin
      if (wr_control) begin
        rx_mode_reg <= req_in.wdata[RX_ENABLE_BIT];
      end
      if (rx_enter) begin
        sample_pending_reg <= 1'b1;
        valid_reg          <= 1'b0;
      end else if (capture) begin
        sample_pending_reg <= 1'b0;
        valid_reg          <= 1'b1;
        strength_reg       <= received_strength_value_in;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      gain_reg  <= 3'h0;
      trim_reg  <= RESET_VALUE;
      slope_reg <= SLOPE_NONE;
    end else if (dev_reset) begin
      gain_reg  <= 3'h0;
      trim_reg  <= RESET_VALUE;
      slope_reg <= SLOPE_NONE;
    end else begin
      // reserved gain bits are not stored and read back as zero
      if (wr_gain) begin
        gain_reg <= req_in.wdata[2:0];
      end
      // trim bit 7 is kept so the host reads back the byte it wrote
      if (wr_trim) begin
        trim_reg <= req_in.wdata;
      end
      // slope reserved bits 5:0 are dropped
      if (wr_slope) begin
        slope_reg <= req_in.wdata[7:6];
      end
    end
  end

  // ==========================================================================
  // read mux; writes to the strength register are ignored
  // the slope register is write-only; its read value means nothing
  logic [7:0] rd_value;
  assign rd_value =
    (req_in.addr == ADDR_STRENGTH) ? {2'h0, valid_reg, strength_reg} :
    (req_in.addr == ADDR_GAIN)     ? {5'h00, gain_reg} :
    (req_in.addr == ADDR_TRIM)     ? trim_reg :
    UNDEF_READ;

  // ==========================================================================
  // slope decode
  // reserved code 01 falls through to no adjustment
  slope_adjust_t slope_mode;
  assign slope_mode = (slope_reg == SLOPE_WIDE)   ? ADJ_WIDE :
                      (slope_reg == SLOPE_NARROW) ? ADJ_NARROW : ADJ_NONE;

  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg  <= 8'h00;
      refout_reg <= 1'b0;
    end else begin
      // read data holds until the next read
      if (req_in.rd) begin
        rdata_reg <= rd_value;
      end
      // the pin stays low while bit 6 is set, whatever the reference does
      refout_reg <= refclk_level_reg && !trim_reg[CLK_DISABLE_BIT];
    end
  end

  // ==========================================================================
  // slope select output, one cycle behind the stored field
  logic [1:0] slope_out_reg;
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      slope_out_reg <= 2'h0;
    end else begin
      slope_out_reg <= (slope_mode == ADJ_WIDE)   ? SLOPE_WIDE :
                       (slope_mode == ADJ_NARROW) ? SLOPE_NARROW : SLOPE_NONE;
    end
  end

  // ==========================================================================
  // outputs, each straight from a flop
  assign rdata_out                   = rdata_reg;
  assign reference_clock_out_pin_out = refout_reg;
  assign amp_gain_setting_out        = gain_reg;
  assign crystal_trim_out            = trim_reg[5:0];
  assign oscillator_slope_select_out = slope_out_reg;

endmodule

`default_nettype wire

// ---- verif/radio_regs_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// port checks of the register bank
module radio_regs_props
  import radio_regs_pkg::*;
(
  input wire logic                     mclk_in,
  input wire logic                     nrst_in,
  input wire radio_regs_pkg::reg_req_t req_in,
  input wire logic                     rx_sample_in,
  input wire logic [4:0]               received_strength_value_in,
  input wire logic                     ref_clock_in,
  input wire logic [7:0]               rdata_out,
  input wire logic                     reference_clock_out_pin_out,
  input wire logic [2:0]               amp_gain_setting_out,
  input wire logic [5:0]               crystal_trim_out,
  input wire logic [1:0]               oscillator_slope_select_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  wire logic [5:0] a = req_in.addr;
  wire logic       w = req_in.wr;
  wire logic       r = req_in.rd;
  wire logic [7:0] d = req_in.wdata;
  sequence s_off; w && a == ADDR_TRIM && d[6] ##1 !w [*2]; endsequence
  property p_gain; w && a == ADDR_GAIN |=> amp_gain_setting_out == $past(d[2:0]); endproperty
  property p_trim; w && a == ADDR_TRIM |=> crystal_trim_out == $past(d[5:0]); endproperty
  property p_clk; s_off |=> !reference_clock_out_pin_out; endproperty
  property p_ro; r && a == ADDR_STRENGTH |=> rdata_out[7:6] == 2'h0; endproperty
  property p_slope; w && a == ADDR_SLOPE |-> ##2 oscillator_slope_select_out ==
    ($past(d[7], 2) ? $past(d[7:6], 2) : SLOPE_NONE); endproperty
  property p_dres; w && a == ADDR_ANALOG && d[0] |=> amp_gain_setting_out == 3'h0 &&
    crystal_trim_out == 6'h00 ##1 oscillator_slope_select_out == SLOPE_NONE; endproperty
  property p_rgain; r && a == ADDR_GAIN |=> rdata_out == {5'h00, $past(amp_gain_setting_out)};
  endproperty
  property p_rtrim; r && a == ADDR_TRIM |=> rdata_out[5:0] == $past(crystal_trim_out); endproperty
  a_gain: assert property (p_gain) else $error("gain write lost");
  a_trim: assert property (p_trim) else $error("trim write lost");
  a_clk: assert property (p_clk) else $error("ref clock not stopped");
  a_ro: assert property (p_ro) else $error("strength top bits set");
  a_slope: assert property (p_slope) else $error("slope decode wrong");
  a_dres: assert property (p_dres) else $error("device reset missed");
  a_rgain: assert property (p_rgain) else $error("gain read wrong");
  a_rtrim: assert property (p_rtrim) else $error("trim read wrong");
endmodule
`default_nettype wire

// ---- verif/radio_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// host side of the register port
module radio_host_model
  import radio_regs_pkg::*;
(
  input  wire logic                    mclk_in,
  output var radio_regs_pkg::reg_req_t req_out
);
  initial req_out = '0;
  function automatic logic [7:0] keep(input logic [5:0] a);
    case (a)
      ADDR_GAIN:  keep = 8'h07;
      ADDR_TRIM:  keep = 8'h7F;
      ADDR_SLOPE: keep = 8'hC0;
      default:    keep = 8'hFF;
    endcase
  endfunction
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(negedge mclk_in);
    req_out = '{w, !w, a, d & keep(a)};
    @(negedge mclk_in);
    req_out = '{1'b0, 1'b0, a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- verif/test_radio_tuning_status_regs.sv ----
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// register bank bench
module test_radio_tuning_status_regs;
  import radio_regs_pkg::*;
  logic                     mclk_in, ref_clock_in, nrst_in = 0, rx_sample_in = 0;
  logic [4:0]               received_strength_value_in = 5'h00;
  logic [7:0]               rdata_out;
  logic [2:0]               amp_gain_setting_out;
  logic [5:0]               crystal_trim_out;
  logic [1:0]               oscillator_slope_select_out;
  logic                     reference_clock_out_pin_out;
  radio_regs_pkg::reg_req_t req_in;
  int                       errors = 0, n_tests = 0, v, e, m [64];
  radio_host_model i_host (.mclk_in(mclk_in), .req_out(req_in));
  radio_tuning_status_regs i_dut (
    .mclk_in                     (mclk_in),
    .nrst_in                     (nrst_in),
    .req_in                      (req_in),
    .rx_sample_in                (rx_sample_in),
    .received_strength_value_in  (received_strength_value_in),
    .ref_clock_in                (ref_clock_in),
    .rdata_out                   (rdata_out),
    .reference_clock_out_pin_out (reference_clock_out_pin_out),
    .amp_gain_setting_out        (amp_gain_setting_out),
    .crystal_trim_out            (crystal_trim_out),
    .oscillator_slope_select_out (oscillator_slope_select_out)
  );
  initial begin
    mclk_in = 0;
    forever #20 mclk_in = ~mclk_in;
  end
  initial begin
    ref_clock_in = 0;
    // slow enough that each level spans two samples of the pin filter
    forever #90 ref_clock_in = ~ref_clock_in;
  end
  task automatic chk(input string s, input logic [7:0] x, input logic [7:0] g);
    n_tests++;
    if (g !== x) begin
      errors++;
      $display("BAD %s exp %h got %h", s, x, g);
    end
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] x);
    i_host.acc(1'b0, a, 8'h00);
    chk("rdata", x, rdata_out);
  endtask
  task automatic samp(input logic [4:0] s);
    @(negedge mclk_in);
    rx_sample_in = 1;
    received_strength_value_in = s;
    @(negedge mclk_in);
    rx_sample_in = 0;
    received_strength_value_in = ~s;
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    final_report;
  end
  initial begin
    m = '{default: 0};
    v = $urandom(32'h3914);
    repeat (12) @(negedge mclk_in);
    nrst_in = 1;
    repeat (3) @(posedge mclk_in);
    for (int a = 34; a < 38; a++) rd(6'(a), 8'(m[a]));
    for (int i = 0; i < 8; i++) begin
      m[35] = i;
      i_host.acc(1'b1, ADDR_GAIN, 8'($urandom) & 8'hF8 | 8'(i));
      chk("gain", 8'(m[35]), {5'h00, amp_gain_setting_out});
      rd(ADDR_GAIN, 8'(m[35]));
    end
    repeat (6) begin
      v = $urandom;
      m[36] = v & 127;
      i_host.acc(1'b1, ADDR_TRIM, 8'(v));
      chk("trim", 8'(m[36] & 63), {2'h0, crystal_trim_out});
      rd(ADDR_TRIM, 8'(m[36]));
      e = 0;
      repeat (16) @(negedge mclk_in) e |= reference_clock_out_pin_out;
      chk("refclk", 8'(!v[6]), 8'(e));
    end
    for (int i = 0; i < 4; i++) begin
      i_host.acc(1'b1, ADDR_SLOPE, 8'(i << 6));
      @(negedge mclk_in);
      chk("slope", i > 1 ? 8'(i) : 8'h00, {6'h00, oscillator_slope_select_out});
    end
    i_host.acc(1'b1, ADDR_CONTROL, 8'h80);
    i_host.acc(1'b0, ADDR_STRENGTH, 8'h00);
    chk("valid", 8'h00, rdata_out & 8'hE0);
    samp(v[4:0]);
    m[34] = 32 | v & 31;
    rd(ADDR_STRENGTH, 8'(m[34]));
    samp(~v[4:0]);
    i_host.acc(1'b1, ADDR_STRENGTH, 8'hFF);
    rd(ADDR_STRENGTH, 8'(m[34]));
    i_host.acc(1'b1, ADDR_CONTROL, 8'h00);
    i_host.acc(1'b1, ADDR_CONTROL, 8'h80);
    samp(5'h1F);
    rd(ADDR_STRENGTH, 8'h3F);
    i_host.acc(1'b1, ADDR_ANALOG, 8'h01);
    for (int a = 34; a < 37; a++) rd(6'(a), 8'h00);
    chk("slope", 8'h00, {6'h00, oscillator_slope_select_out});
    final_report;
  end
endmodule
bind radio_tuning_status_regs radio_regs_props i_props (.*);
`default_nettype wire
